// *** verilog/iqs_top.sv ***
// Converter sequencer, offset and control registers, fault blanking, short selector
// Operation
// - Separate 8-bit I and Q offset codes, written 0x38/0x39, read 0x28/0x29.
// - Each offset count lowers converter input by 80 counts before accumulation.
// - 8-bit conversion control register, written 0x3A, read 0x2A.
// - Bits 7:6 pick settling 1600, 2304, 2656 or 1600 system clocks.
// - Bits 5:4 pick 4, 8, 16 or 4 samples per channel.
// - Bits 3:2 pick converter clock period 16, 8, 4 or 16 clocks.
// - Bits 1:0: reset/stop, single start, continuous start, stop current.
// - Single start waits settling, then samples and accumulates programmed count.
// - I and Q samples interleave; a select output switches converter input.
// - Single done copies results out and sets completion flag.
// - Continuous mode repeats accumulations, stored as matched I/Q pairs.
// - State value 0 aborts conversion and zeroes both accumulators at once.
// - 6-bit blanking limit 0x3B; fault reported once its counter reaches it.
// - Each fault has own up/down counter stepped once per sine zero crossing.
// - Reported faults stay latched until status read; counter then restarts.
// - Active fault pulse beats the read-triggered clear of its latch.
// - Command 0x3C loads two 4-bit short selectors; power-on value all off.
// - Selector codes 0-9 pick sensor pins, 1011 shield, others nothing.
// - Configuration loaded within 8190 clocks, then signal processor enabled.
// - Host commands accepted from 128 clocks after power-on.
// - Completion flag clears on pair read or new conversion start.
// - I and Q result registers return to zero after being read.
// - All this logic runs on the divided system clock.
`timescale 1ns/1ps
module iqs_top #(
  parameter int NFAULT = 6,
  parameter int CFG_CYCLES = iqs_pkg::CFG_LOAD_CYCLES
) (
  // Clock and reset (divided system clock)
  input wire logic clk_sys,
  input wire logic nrst,
  // Host command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic [13:0] cmd_rdata,
  output logic [13:0] cmd_rdata_q,
  output logic cmd_ready,
  // Configuration download
  input wire logic cfg_restart,
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_sel,
  input wire logic [7:0] cfg_data,
  output logic cfg_done,
  // Converter side
  input wire logic [9:0] adc_sample,
  output logic converter_clock,
  output logic iq_input_select,
  output logic [7:0] i_offset_code,
  output logic [7:0] q_offset_code,
  output logic busy,
  // Faults
  input wire logic sine_zero_crossing,
  input wire logic [NFAULT-1:0] fault_in,
  // Short-detection selectors, one-hot over 10 sensors plus shield
  output logic [10:0] short_plus_sel,
  output logic [10:0] short_minus_sel
);
  logic [7:0] i_off_r, q_off_r, ctl_r, short_r;
  logic [5:0] blank_r;
  logic [13:0] i_acc_r, q_acc_r, i_res_r, q_res_r;
  logic done_r;
  iqs_pkg::iqs_seq_e seq_r;
  logic [11:0] settle_cnt_r;
  logic [4:0] clk_cnt_r;
  logic [4:0] samp_cnt_r;
  logic phase_q_r;
  logic [13:0] boot_cnt_r;
  logic boot_done_r;
  logic [NFAULT-1:0] flt_r;
  logic [5:0] fcnt_r [NFAULT];
  logic [13:0] rd_nxt;

  logic wr, rd;
  logic [11:0] settle_len;
  logic [4:0] cclk_len, nsamp;
  logic ctl_wr, start_wr, reset_wr, pair_rd, stat_rd;
  logic [13:0] samp_adj;
  assign wr = cmd_valid & cmd_write & cmd_ready;
  assign rd = cmd_valid & ~cmd_write & cmd_ready;
  assign ctl_wr = wr && cmd_code == iqs_pkg::CMD_WR_CONV_CTL;
  assign start_wr = ctl_wr && (cmd_wdata[1:0] == iqs_pkg::ST_SINGLE ||
                               cmd_wdata[1:0] == iqs_pkg::ST_CONT);
  assign reset_wr = ctl_wr && cmd_wdata[1:0] == iqs_pkg::ST_RESET;
  assign pair_rd = rd && cmd_code == iqs_pkg::CMD_RD_IQ_PAIR;
  assign stat_rd = rd && cmd_code == iqs_pkg::CMD_RD_STATUS;

  // Field decodes
  always_comb begin
    case (ctl_r[iqs_pkg::CTL_SETTLE_LSB +: 2])
      2'h1: settle_len = iqs_pkg::SETTLE_B;
      2'h2: settle_len = iqs_pkg::SETTLE_C;
      default: settle_len = iqs_pkg::SETTLE_A;
    endcase
    case (ctl_r[iqs_pkg::CTL_ACCUM_LSB +: 2])
      2'h1: nsamp = iqs_pkg::NSAMP_8;
      2'h2: nsamp = iqs_pkg::NSAMP_16;
      default: nsamp = iqs_pkg::NSAMP_4;
    endcase
    case (ctl_r[iqs_pkg::CTL_CLK_LSB +: 2])
      2'h1: cclk_len = iqs_pkg::CCLK_8;
      2'h2: cclk_len = iqs_pkg::CCLK_4;
      default: cclk_len = iqs_pkg::CCLK_16;
    endcase
  end

  // Offset subtraction: saturates at zero so a large code cannot wrap
  logic [14:0] off_sub;
  assign off_sub = 15'(phase_q_r ? q_off_r : i_off_r) * 15'(iqs_pkg::OFFSET_STEP);
  assign samp_adj = ({5'h00, adc_sample} > off_sub) ?
                    14'({5'h00, adc_sample} - off_sub) : 14'h0000;

  // Power-on counters
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      boot_cnt_r <= 14'h0000;
      boot_done_r <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      if (cfg_restart) begin
        boot_cnt_r <= 14'h0000;
        boot_done_r <= 1'b0;
      end else if (!boot_done_r) begin
        boot_cnt_r <= boot_cnt_r + 14'h0001;
        if (boot_cnt_r == 14'(CFG_CYCLES - 1)) begin
          boot_done_r <= 1'b1;
        end
      end
      // Stays up across later reloads: host access runs in parallel
      if (boot_cnt_r == 14'(iqs_pkg::CMD_READY_CYCLES - 1)) begin
        cmd_ready <= 1'b1;
      end
    end
  end
  assign cfg_done = boot_done_r;

  // Settings registers: download and host writes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      i_off_r <= iqs_pkg::OFFSET_RST;
      q_off_r <= iqs_pkg::OFFSET_RST;
      ctl_r <= iqs_pkg::CONV_CTL_RST;
      blank_r <= iqs_pkg::BLANK_RST;
      short_r <= iqs_pkg::SHORT_SEL_RST;
    end else if (cfg_wr && !boot_done_r) begin
      case (cfg_sel)
        3'h0: i_off_r <= cfg_data;
        3'h1: q_off_r <= cfg_data;
        3'h2: blank_r <= cfg_data[5:0];
        3'h3: short_r <= cfg_data;
        default: ;
      endcase
    end else if (wr) begin
      case (cmd_code)
        iqs_pkg::CMD_WR_I_OFFSET: i_off_r <= cmd_wdata;
        iqs_pkg::CMD_WR_Q_OFFSET: q_off_r <= cmd_wdata;
        iqs_pkg::CMD_WR_CONV_CTL: ctl_r <= cmd_wdata;
        iqs_pkg::CMD_WR_BLANK: blank_r <= cmd_wdata[5:0];
        iqs_pkg::CMD_WR_SHORT_SEL: short_r <= cmd_wdata;
        default: ;
      endcase
    end
  end
  assign i_offset_code = i_off_r;
  assign q_offset_code = q_off_r;

  // Sequencer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      seq_r <= iqs_pkg::SQ_IDLE;
      settle_cnt_r <= 12'h000;
      clk_cnt_r <= 5'h00;
      samp_cnt_r <= 5'h00;
      phase_q_r <= 1'b0;
      i_acc_r <= 14'h0000;
      q_acc_r <= 14'h0000;
      converter_clock <= 1'b0;
      busy <= 1'b0;
    end else if (reset_wr || !boot_done_r) begin
      seq_r <= iqs_pkg::SQ_IDLE;
      busy <= 1'b0;
      i_acc_r <= 14'h0000;
      q_acc_r <= 14'h0000;
      phase_q_r <= 1'b0;
      converter_clock <= 1'b0;
    end else if (ctl_wr && cmd_wdata[1:0] == iqs_pkg::ST_STOP) begin
      seq_r <= iqs_pkg::SQ_HALT;
      converter_clock <= 1'b0;
      busy <= 1'b1;
    end else if (start_wr && seq_r == iqs_pkg::SQ_IDLE) begin
      seq_r <= iqs_pkg::SQ_SETTLE;
      busy <= 1'b1;
      settle_cnt_r <= 12'h000;
    end else begin
      case (seq_r)
        iqs_pkg::SQ_SETTLE: begin
          settle_cnt_r <= settle_cnt_r + 12'h001;
          if (settle_cnt_r == settle_len - 12'h001) begin
            seq_r <= iqs_pkg::SQ_SAMPLE;
            clk_cnt_r <= 5'h00;
            samp_cnt_r <= 5'h00;
            phase_q_r <= 1'b0;
            i_acc_r <= 14'h0000;
            q_acc_r <= 14'h0000;
          end
        end
        iqs_pkg::SQ_SAMPLE: begin
          clk_cnt_r <= (clk_cnt_r == cclk_len - 5'h01) ? 5'h00 : clk_cnt_r + 5'h01;
          converter_clock <= clk_cnt_r < (cclk_len >> 1);
          if (clk_cnt_r == cclk_len - 5'h01) begin
            if (phase_q_r) begin
              q_acc_r <= q_acc_r + samp_adj;
              samp_cnt_r <= samp_cnt_r + 5'h01;
            end else begin
              i_acc_r <= i_acc_r + samp_adj;
            end
            phase_q_r <= ~phase_q_r;
            if (phase_q_r && samp_cnt_r == nsamp - 5'h01) begin
              seq_r <= iqs_pkg::SQ_DONE;
            end
          end
        end
        iqs_pkg::SQ_DONE: begin
          // Continuous restarts accumulation without settling again
          if (ctl_r[1:0] == iqs_pkg::ST_CONT) begin
            seq_r <= iqs_pkg::SQ_SAMPLE;
            samp_cnt_r <= 5'h00;
            clk_cnt_r <= 5'h00;
            i_acc_r <= 14'h0000;
            q_acc_r <= 14'h0000;
          end else begin
            seq_r <= iqs_pkg::SQ_HALT;
          end
        end
        iqs_pkg::SQ_HALT: converter_clock <= 1'b0;
        iqs_pkg::SQ_IDLE: converter_clock <= 1'b0;
        default: begin
          seq_r <= iqs_pkg::SQ_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
  assign iq_input_select = phase_q_r;

  // Result registers and completion flag
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      i_res_r <= 14'h0000;
      q_res_r <= 14'h0000;
      done_r <= 1'b0;
    end else if (seq_r == iqs_pkg::SQ_DONE) begin
      i_res_r <= i_acc_r;
      q_res_r <= q_acc_r;
      done_r <= 1'b1;
    end else begin
      if (pair_rd || reset_wr || start_wr) begin
        done_r <= 1'b0;
      end
      if (pair_rd || (rd && cmd_code == iqs_pkg::CMD_RD_I_DATA)) begin
        i_res_r <= 14'h0000;
      end
      if (pair_rd || (rd && cmd_code == iqs_pkg::CMD_RD_Q_DATA)) begin
        q_res_r <= 14'h0000;
      end
    end
  end

  // Fault blanking, one counter per fault
  genvar g;
  generate
    for (g = 0; g < NFAULT; g++) begin : g_flt
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          fcnt_r[g] <= 6'h00;
          flt_r[g] <= 1'b0;
        end else begin
          if (sine_zero_crossing && !flt_r[g]) begin
            if (fault_in[g] && fcnt_r[g] != blank_r) begin
              fcnt_r[g] <= fcnt_r[g] + 6'h01;
            end else if (!fault_in[g] && fcnt_r[g] != 6'h00) begin
              fcnt_r[g] <= fcnt_r[g] - 6'h01;
            end
          end
          if (stat_rd && flt_r[g]) begin
            fcnt_r[g] <= 6'h00;
          end
          // Set wins over the clear from the status read
          if (sine_zero_crossing && fault_in[g] && fcnt_r[g] + 6'h01 >= blank_r) begin
            flt_r[g] <= 1'b1;
          end else if (stat_rd) begin
            flt_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Short selector decode
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      short_plus_sel <= 11'h000;
      short_minus_sel <= 11'h000;
    end else begin
      for (int k = 0; k < 10; k++) begin
        short_plus_sel[k] <= short_r[7:4] == 4'(k);
        short_minus_sel[k] <= short_r[3:0] == 4'(k);
      end
      short_plus_sel[10] <= short_r[7:4] == iqs_pkg::SEL_SHIELD;
      short_minus_sel[10] <= short_r[3:0] == iqs_pkg::SEL_SHIELD;
    end
  end

  // Read data, registered one cycle after the request
  always_comb begin
    rd_nxt = 14'h0000;
    case (cmd_code)
      iqs_pkg::CMD_RD_I_OFFSET: rd_nxt = {6'h00, i_off_r};
      iqs_pkg::CMD_RD_Q_OFFSET: rd_nxt = {6'h00, q_off_r};
      iqs_pkg::CMD_RD_CONV_CTL: rd_nxt = {6'h00, ctl_r};
      iqs_pkg::CMD_RD_BLANK: rd_nxt = {8'h00, blank_r};
      iqs_pkg::CMD_RD_SHORT_SEL: rd_nxt = {6'h00, short_r};
      iqs_pkg::CMD_RD_STATUS: rd_nxt = 14'(flt_r);
      iqs_pkg::CMD_RD_I_DATA: rd_nxt = i_res_r;
      iqs_pkg::CMD_RD_Q_DATA: rd_nxt = q_res_r;
      iqs_pkg::CMD_RD_IQ_PAIR: rd_nxt = i_res_r;
      iqs_pkg::CMD_RD_DONE: rd_nxt = {13'h0000, done_r};
      default: rd_nxt = 14'h0000;
    endcase
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmd_rdata <= 14'h0000;
      cmd_rdata_q <= 14'h0000;
    end else if (rd) begin
      cmd_rdata <= rd_nxt;
      cmd_rdata_q <= (cmd_code == iqs_pkg::CMD_RD_IQ_PAIR) ? q_res_r : 14'h0000;
    end
  end
endmodule

// *** verilog/iqs_pkg.sv ***
// Package of constants for the I/Q converter sequencer and fault blanking block
package iqs_pkg;
  // Command codes (writes and reads)
  localparam logic [7:0] CMD_WR_I_OFFSET = 8'h38;
  localparam logic [7:0] CMD_WR_Q_OFFSET = 8'h39;
  localparam logic [7:0] CMD_WR_CONV_CTL = 8'h3A;
  localparam logic [7:0] CMD_WR_BLANK = 8'h3B;
  localparam logic [7:0] CMD_WR_SHORT_SEL = 8'h3C;
  localparam logic [7:0] CMD_RD_I_OFFSET = 8'h28;
  localparam logic [7:0] CMD_RD_Q_OFFSET = 8'h29;
  localparam logic [7:0] CMD_RD_CONV_CTL = 8'h2A;
  localparam logic [7:0] CMD_RD_BLANK = 8'h2B;
  localparam logic [7:0] CMD_RD_SHORT_SEL = 8'h2C;
  localparam logic [7:0] CMD_RD_STATUS = 8'h02;
  localparam logic [7:0] CMD_RD_I_DATA = 8'h03;
  localparam logic [7:0] CMD_RD_Q_DATA = 8'h04;
  localparam logic [7:0] CMD_RD_DONE = 8'h05;
  localparam logic [7:0] CMD_RD_IQ_PAIR = 8'h90;
  // Reset values
  localparam logic [7:0] SHORT_SEL_RST = 8'hFF;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [7:0] CONV_CTL_RST = 8'h00;
  localparam logic [5:0] BLANK_RST = 6'h00;
  // Control field positions
  localparam int CTL_SETTLE_LSB = 6;
  localparam int CTL_ACCUM_LSB = 4;
  localparam int CTL_CLK_LSB = 2;
  localparam int CTL_STATE_LSB = 0;
  // State commands
  localparam logic [1:0] ST_RESET = 2'h0;
  localparam logic [1:0] ST_SINGLE = 2'h1;
  localparam logic [1:0] ST_CONT = 2'h2;
  localparam logic [1:0] ST_STOP = 2'h3;
  // Timing counts in system clock periods, then sample counts and the offset step in converter counts
  localparam logic [11:0] SETTLE_A = 12'd1600;
  localparam logic [11:0] SETTLE_B = 12'd2304;
  localparam logic [11:0] SETTLE_C = 12'd2656;
  localparam logic [4:0] CCLK_16 = 5'd16;
  localparam logic [4:0] CCLK_8 = 5'd8;
  localparam logic [4:0] CCLK_4 = 5'd4;
  localparam logic [4:0] NSAMP_4 = 5'd4;
  localparam logic [4:0] NSAMP_8 = 5'd8;
  localparam logic [4:0] NSAMP_16 = 5'd16;
  localparam logic [13:0] OFFSET_STEP = 14'd80;
  localparam int CFG_LOAD_CYCLES = 8190;
  localparam int CMD_READY_CYCLES = 128;
  // Short selector decode
  localparam logic [3:0] SEL_LAST_SENSOR = 4'h9;
  localparam logic [3:0] SEL_SHIELD = 4'hB;
  // Sequencer states
  typedef enum logic [4:0] {
    SQ_IDLE = 5'b00001,
    SQ_SETTLE = 5'b00010,
    SQ_SAMPLE = 5'b00100,
    SQ_DONE = 5'b01000,
    SQ_HALT = 5'b10000
  } iqs_seq_e;
endpackage

// *** verif/iqs_checker.sv ***
// Assertion checker for the converter sequencer block
`timescale 1ns/1ps
module iqs_checker #(
  parameter int NFAULT = 6,
  parameter int CFG_CYCLES = 8190
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Host port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  input wire logic [13:0] cmd_rdata_q,
  input wire logic cmd_ready,
  // Download and converter
  input wire logic cfg_restart,
  input wire logic cfg_wr,
  input wire logic cfg_done,
  input wire logic converter_clock,
  input wire logic [7:0] i_offset_code,
  input wire logic busy,
  // Short selectors
  input wire logic [10:0] short_plus_sel,
  input wire logic [10:0] short_minus_sel
);
  // Saturating counters, so long runs never wrap
  int up_r;
  int cf_r;
  logic wr_ok;
  assign wr_ok = cmd_valid && cmd_ready && cmd_write && !(cfg_wr && !cfg_done);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) up_r <= 0;
    else if (up_r < 30000) up_r <= up_r + 1;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) cf_r <= 0;
    else if (cfg_restart) cf_r <= 0;
    else if (cf_r < 30000) cf_r <= cf_r + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_ready_early: assert property (up_r < 126 |-> !cmd_ready)
    else $error("host port open too early");
  a_ready_late: assert property (up_r > 130 |-> cmd_ready)
    else $error("host port not open");
  a_cfg_window: assert property (cf_r < CFG_CYCLES - 2 |-> !cfg_done)
    else $error("download done too early");
  a_cfg_end: assert property (cf_r > CFG_CYCLES + 2 |-> cfg_done)
    else $error("download not done in time");
  a_idle_loading: assert property (!cfg_done [*2] |-> !busy)
    else $error("sequencer ran during download");
  a_start_busy: assert property (wr_ok && cmd_code == 8'h3A && cmd_wdata[1:0] == 2'h1
    && !busy && cfg_done |=> busy)
    else $error("start not taken");
  a_abort_idle: assert property (wr_ok && cmd_code == 8'h3A && cmd_wdata[1:0] == 2'h0
    |-> ##[1:2] !busy)
    else $error("abort not immediate");
  a_settle_quiet: assert property ($rose(busy) |-> !converter_clock [*8])
    else $error("converter clock during settling");
  a_clk_stopped: assert property (!busy && !$past(busy) |-> !converter_clock)
    else $error("converter clock while idle");
  a_q_zero: assert property (cmd_valid && cmd_ready && !cmd_write && cmd_code != 8'h90
    |-> ##[1:2] cmd_rdata_q == 14'h0000)
    else $error("second word on single read");
  a_offset_load: assert property (wr_ok && cmd_code == 8'h38
    |=> i_offset_code == $past(cmd_wdata))
    else $error("offset not loaded");
  a_offset_hold: assert property (!(wr_ok && cmd_code == 8'h38) && !cfg_wr && !cfg_restart
    |=> $stable(i_offset_code))
    else $error("offset changed by itself");
  a_sel_onehot: assert property ($onehot0(short_plus_sel) && $onehot0(short_minus_sel))
    else $error("short selector not one-hot");
endmodule

bind iqs_top iqs_checker #(.NFAULT(NFAULT), .CFG_CYCLES(CFG_CYCLES)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata_q(cmd_rdata_q),
  .cmd_ready(cmd_ready), .cfg_restart(cfg_restart), .cfg_wr(cfg_wr), .cfg_done(cfg_done),
  .converter_clock(converter_clock), .i_offset_code(i_offset_code), .busy(busy),
  .short_plus_sel(short_plus_sel), .short_minus_sel(short_minus_sel));

// *** verif/iqs_afe_model.sv ***
// Analog front end model: channel samples and sine zero crossing strobe
`timescale 1ns/1ps
module iqs_afe_model #(
  parameter logic [9:0] I_VAL = 10'h258,
  parameter logic [9:0] Q_VAL = 10'h384,
  parameter int ZC_PER = 24
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Converter side
  input wire logic iq_input_select,
  output logic [9:0] adc_sample,
  // Zero crossing strobe
  output logic sine_zero_crossing
);
  int zc_r;
  // Distinct levels per channel, so a swapped select shows in the sums
  assign adc_sample = iq_input_select ? Q_VAL : I_VAL;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      zc_r <= 0;
      sine_zero_crossing <= 1'b0;
    end else begin
      zc_r <= (zc_r == ZC_PER - 1) ? 0 : zc_r + 1;
      sine_zero_crossing <= (zc_r == ZC_PER - 1);
    end
  end
endmodule

// *** verif/iqs_tb.sv ***
// Self-checking testbench for the converter sequencer block
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [5:0] fault_in = 6'h00;
  logic cfg_restart = 1'b0;
  logic cfg_wr = 1'b0;
  logic [2:0] cfg_sel = 3'h0;
  logic [7:0] cfg_data = 8'h00;
  logic [13:0] cmd_rdata, cmd_rdata_q, rd_i, rd_q;
  logic cmd_ready, cfg_done, converter_clock, iq_input_select, busy, zc;
  logic [9:0] adc_sample;
  logic [7:0] i_off, q_off, a, b;
  logic [10:0] sp, sm;
  logic [5:0] m;
  int n_fail = 0;
  int n_checks = 0;
  always #4 clk_sys = ~clk_sys;
  iqs_top #(.CFG_CYCLES(200)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rdata_q(cmd_rdata_q), .cmd_ready(cmd_ready), .cfg_restart(cfg_restart),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_data(cfg_data), .cfg_done(cfg_done),
    .adc_sample(adc_sample),
    .converter_clock(converter_clock), .iq_input_select(iq_input_select),
    .i_offset_code(i_off), .q_offset_code(q_off), .busy(busy), .sine_zero_crossing(zc),
    .fault_in(fault_in), .short_plus_sel(sp), .short_minus_sel(sm));
  iqs_afe_model i_afe (.clk_sys(clk_sys), .nrst(nrst), .iq_input_select(iq_input_select),
    .adc_sample(adc_sample), .sine_zero_crossing(zc));
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check_eq(input logic [13:0] seen, input logic [13:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  // One pulse per access; read data is sampled once it has settled
  task automatic access(input logic wr, input logic [7:0] code, input logic [7:0] data);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    tick();
    rd_i = cmd_rdata;
    rd_q = cmd_rdata_q;
  endtask
  task automatic wait_zc(input int n);
    repeat (n) begin
      tick();
      while (zc !== 1'b1) tick();
      @(posedge clk_sys);
    end
  endtask
  function automatic int settle_of(input logic [1:0] k);
    return (k == 2'h1) ? 2304 : (k == 2'h2) ? 2656 : 1600;
  endfunction
  function automatic int nsamp_of(input logic [1:0] k);
    return (k == 2'h1) ? 8 : (k == 2'h2) ? 16 : 4;
  endfunction
  function automatic int cclk_of(input logic [1:0] k);
    return (k == 2'h1) ? 8 : (k == 2'h2) ? 4 : 16;
  endfunction
  function automatic logic [13:0] acc_of(input int v, input logic [7:0] off, input int n);
    return (v > 80 * off) ? 14'(n * (v - 80 * off)) : 14'h0000;
  endfunction
  function automatic logic [13:0] dec_of(input logic [3:0] c);
    return (c <= 4'h9) ? 14'(1 << c) : (c == 4'hB) ? 14'h0400 : 14'h0000;
  endfunction
  task automatic run_single(input logic [1:0] k, input logic [7:0] oi, input logic [7:0] oq);
    int t;
    int p;
    t = 0;
    p = 0;
    access(1'b1, 8'h38, oi);
    access(1'b1, 8'h39, oq);
    access(1'b1, 8'h3A, {k, k, k, 2'h0});
    access(1'b1, 8'h3A, {k, k, k, 2'h1});
    while (converter_clock !== 1'b1 && t < 4000) begin tick(); t++; end
    check_eq(14'(t >= settle_of(k) - 4 && t <= settle_of(k) + 4), 14'h0001);
    while (converter_clock === 1'b1 && p < 40) begin tick(); p++; end
    while (converter_clock !== 1'b1 && p < 40) begin tick(); p++; end
    check_eq(14'(p), 14'(cclk_of(k)));
    repeat (cclk_of(k) * 2 * nsamp_of(k) + 40) tick();
    access(1'b0, 8'h05, 8'h00);
    check_eq(rd_i, 14'h0001);
    access(1'b0, 8'h90, 8'h00);
    check_eq(rd_i, acc_of(600, oi, nsamp_of(k)));
    check_eq(rd_q, acc_of(900, oq, nsamp_of(k)));
    access(1'b0, 8'h05, 8'h00);
    check_eq(rd_i, 14'h0000);
    access(1'b0, 8'h03, 8'h00);
    check_eq(rd_i, 14'h0000);
    access(1'b0, 8'h04, 8'h00);
    check_eq(rd_i, 14'h0000);
    access(1'b1, 8'h3A, 8'h00);
  endtask
  initial begin
    void'($urandom(32'h89dd));
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    access(1'b1, 8'h38, 8'h5A);
    for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++) tick();
    check_eq(14'(cfg_done), 14'h0000);
    access(1'b0, 8'h28, 8'h00);
    check_eq(rd_i, 14'h0000);
    access(1'b0, 8'h2C, 8'h00);
    check_eq(rd_i, 14'h00FF);
    check_eq({3'h0, sp | sm}, 14'h0000);
    access(1'b1, 8'h3A, 8'h01);
    check_eq(14'(busy), 14'h0000);
    access(1'b1, 8'h3A, 8'h00);
    for (int j = 0; j < 4; j++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      access(1'b1, 8'h38, a);
      access(1'b1, 8'h39, b);
      check_eq({6'h00, i_off}, {6'h00, a});
      check_eq({6'h00, q_off}, {6'h00, b});
      access(1'b0, 8'h28, 8'h00);
      check_eq(rd_i, {6'h00, a});
      access(1'b0, 8'h29, 8'h00);
      check_eq(rd_i, {6'h00, b});
      access(1'b1, 8'h3A, {a[7:2], 2'h0});
      access(1'b0, 8'h2A, 8'h00);
      check_eq(rd_i, {6'h00, a[7:2], 2'h0});
      access(1'b1, 8'h3B, b);
      access(1'b0, 8'h2B, 8'h00);
      check_eq(rd_i, {8'h00, b[5:0]});
    end
    for (int v = 0; v < 16; v++) begin
      access(1'b1, 8'h3C, {4'(v), ~4'(v)});
      check_eq({3'h0, sp}, dec_of(4'(v)));
      check_eq({3'h0, sm}, dec_of(~4'(v)));
    end
    $display("registers test done");
    for (int k = 0; k < 4; k++) begin
      run_single(2'(k), (k == 3) ? 8'hFF : 8'($urandom % 12), 8'($urandom % 12));
    end
    $display("single conversion test done");
    access(1'b1, 8'h3A, 8'h01);
    repeat (1700) tick();
    access(1'b1, 8'h3A, 8'h00);
    check_eq(14'(busy), 14'h0000);
    repeat (700) tick();
    access(1'b0, 8'h90, 8'h00);
    check_eq(rd_i | rd_q, 14'h0000);
    $display("abort test done");
    access(1'b1, 8'h38, 8'h02);
    access(1'b1, 8'h39, 8'h03);
    access(1'b1, 8'h3A, 8'h08);
    access(1'b1, 8'h3A, 8'h0A);
    repeat (1800) tick();
    access(1'b0, 8'h90, 8'h00);
    check_eq(rd_i, 14'd1760);
    check_eq(rd_q, 14'd2640);
    repeat (40) tick();
    access(1'b0, 8'h05, 8'h00);
    check_eq(rd_i, 14'h0001);
    access(1'b0, 8'h90, 8'h00);
    check_eq(rd_i, 14'd1760);
    access(1'b1, 8'h3A, 8'h0B);
    repeat (4) tick();
    a = 8'h00;
    repeat (40) begin tick(); a = a | 8'(converter_clock); end
    check_eq({6'h00, a}, 14'h0000);
    access(1'b1, 8'h3A, 8'h00);
    $display("continuous test done");
    a = 8'($urandom);
    @(posedge clk_sys);
    cfg_restart <= 1'b1;
    @(posedge clk_sys);
    cfg_restart <= 1'b0;
    cfg_wr <= 1'b1;
    cfg_sel <= 3'h3;
    cfg_data <= a;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    tick();
    check_eq(14'(cfg_done), 14'h0000);
    access(1'b0, 8'h2C, 8'h00);
    check_eq(rd_i, {6'h00, a});
    check_eq({3'h0, sp}, dec_of(a[7:4]));
    access(1'b1, 8'h3A, 8'h01);
    check_eq(14'(busy), 14'h0000);
    for (int i = 0; i < 400 && cfg_done !== 1'b1; i++) tick();
    check_eq(14'(cfg_done), 14'h0001);
    check_eq(14'(busy), 14'h0000);
    access(1'b1, 8'h3A, 8'h00);
    $display("configuration reload test done");
    access(1'b1, 8'h3B, 8'h03);
    m = 6'($urandom) | 6'h01;
    wait_zc(1);
    fault_in <= m;
    wait_zc(2);
    fault_in <= 6'h00;
    wait_zc(3);
    access(1'b0, 8'h02, 8'h00);
    check_eq(rd_i, 14'h0000);
    wait_zc(1);
    fault_in <= m;
    wait_zc(3);
    fault_in <= 6'h00;
    wait_zc(2);
    access(1'b0, 8'h02, 8'h00);
    check_eq(rd_i, {8'h00, m});
    access(1'b0, 8'h02, 8'h00);
    check_eq(rd_i, 14'h0000);
    $display("fault blanking test done");
    complete_run();
  end
  // Cuts a hang well beyond the expected run length
  initial begin
    #(60000 * 8);
    n_fail++;
    complete_run();
  end
endmodule
